// File: inc/pg_regs_pkg.sv
// Constants for the limit, transient and power-good register slice
package pg_regs_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CH2_OUTPUT_CODE_ADDR        = 8'hd9;
    localparam logic [7:0] CH3_OUTPUT_CODE_ADDR        = 8'hda;
    localparam logic [7:0] CH2_OUTPUT_LIMITS_ADDR      = 8'hdd;
    localparam logic [7:0] CH3_OUTPUT_LIMITS_ADDR      = 8'hde;
    localparam logic [7:0] FAST_TRANSIENT_CONFIG_ADDR  = 8'hdf;
    localparam logic [7:0] POWER_GOOD_CONFIG_ADDR      = 8'he0;
    localparam logic [7:0] POWER_GOOD_LIVE_STATUS_ADDR = 8'he1;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] OUTPUT_CODE_RST   = 8'h80;
    localparam logic [7:0] OUTPUT_LIMITS_RST = 8'h00;
    localparam logic [5:0] TRANSIENT_RST     = 6'h3f;
    localparam logic [7:0] GOOD_CONFIG_RST   = 8'h10;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int UPPER_LIMIT_MSB  = 7;
    localparam int UPPER_LIMIT_LSB  = 4;
    localparam int LOWER_LIMIT_MSB  = 3;
    localparam int LOWER_LIMIT_LSB  = 0;
    localparam int TRANSIENT_MSB    = 5;
    localparam int GOOD_DELAY_BIT   = 4;
    localparam int GOOD_EXCLUDE_MSB = 2;
    // ------------------------------------------------------------------
    // Voltages in half-millivolt units
    // ------------------------------------------------------------------
    localparam logic [11:0] CODE_BASE_HMV   = 12'h330; // 408 mV
    localparam logic [11:0] CODE_STEP_HMV   = 12'h003; // 1.5 mV
    localparam logic [11:0] UPPER_OFS_HMV   = 12'h180; // 192 mV
    localparam logic [11:0] LOWER_OFS_HMV   = 12'h17d; // 190.5 mV
    localparam logic [11:0] LIMIT_STEP_HMV  = 12'h018; // 12 mV
    localparam logic [11:0] VREF_TRIM_HMV   = 12'h4b0; // 600 mV
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_KHZ   = 10000;
    localparam int TSET_X1_US     = 2600;
    localparam int TSET_X8_US     = 20800;
    localparam int TSET_X1_CYCLES = TSET_X1_US * CLK_FREQ_KHZ / 1000;
    localparam int TSET_X8_CYCLES = TSET_X8_US * CLK_FREQ_KHZ / 1000;
    localparam int DELAY_CNT_W    = 18;
endpackage

// File: rtl/dvs_limit_powergood_regs.sv
// Limit, fast-transient and power-good register slice
`timescale 1ns/1ps

// Overview of operation
// - Channel 2 upper-limit write ignored when its bound sits below the output.
// - Channel 2 lower-limit write ignored when its bound sits above the output.
// - Channel 2 upper bound equals trim reference plus 192 mV minus 12 mV/step.
// - Channel 2 lower bound equals trim reference minus 190.5 mV plus 12 mV/step.
// - Channel 3 upper-limit write ignored when its bound sits below the output.
// - Channel 3 lower-limit write ignored when its bound sits above the output.
// - Channel 3 upper bound equals trim reference plus 192 mV minus 12 mV/step.
// - Channel 3 lower bound equals trim reference minus 190.5 mV plus 12 mV/step.
// - Two-bit transient codes per channel select off or window and gain; reset 3.
// - Transient codes at [5:4],[3:2],[1:0]; config pin off forces all disabled.
// - Good pin is the AND of the per-channel good signals.
// - Exclude bits 2..0 reset 0; a set bit removes its channel from the pin.
// - Delay bit 4 resets 1; pin rises after 2.6 ms or 20.8 ms when set.
// - Live status bits 2..0 show each channel's good level in real time.
// - Channel output code write outside its limits is rejected; reset 0x80.
// - Output code maps to 408 mV plus 1.5 mV per step.
module dvs_limit_powergood_regs #(
    parameter int TSET_X1_CYCLES = pg_regs_pkg::TSET_X1_CYCLES,
    parameter int TSET_X8_CYCLES = pg_regs_pkg::TSET_X8_CYCLES
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic [2:0] ch_good_i,
    input  wire logic       transient_config_pin_i,
    input  wire logic       timer_scale_x8_i,
    output logic      [7:0] ch2_output_code_o,
    output logic      [7:0] ch3_output_code_o,
    output logic      [1:0] ch1_transient_sensitivity_o,
    output logic      [1:0] ch2_transient_sensitivity_o,
    output logic      [1:0] ch3_transient_sensitivity_o,
    output logic            aggregate_good_pin_o
);
    localparam int CW = pg_regs_pkg::DELAY_CNT_W;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]    ch2_code;
        logic [7:0]    ch3_code;
        logic [7:0]    ch2_limits;
        logic [7:0]    ch3_limits;
        logic [5:0]    transient;
        logic          delay_en;
        logic [2:0]    exclude;
        logic [2:0]    good_meta;
        logic [2:0]    good_sync;
        logic          cfg_meta;
        logic          cfg_sync;
        logic [CW-1:0] delay_cnt;
        logic          pin;
        logic [5:0]    transient_eff;
        logic [7:0]    rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ------------------------------------------------------------------
    // Voltage helpers
    // ------------------------------------------------------------------
    function automatic logic [11:0] code_hmv(input logic [7:0] code);
        code_hmv = pg_regs_pkg::CODE_BASE_HMV
                 + 12'(pg_regs_pkg::CODE_STEP_HMV * {4'h0, code});
    endfunction

    function automatic logic [11:0] upper_hmv(input logic [3:0] lim);
        upper_hmv = pg_regs_pkg::VREF_TRIM_HMV + pg_regs_pkg::UPPER_OFS_HMV
                  - 12'(pg_regs_pkg::LIMIT_STEP_HMV * {8'h00, lim});
    endfunction

    function automatic logic [11:0] lower_hmv(input logic [3:0] lim);
        lower_hmv = pg_regs_pkg::VREF_TRIM_HMV - pg_regs_pkg::LOWER_OFS_HMV
                  + 12'(pg_regs_pkg::LIMIT_STEP_HMV * {8'h00, lim});
    endfunction

    // New limit byte: each field taken only if it still covers the output
    function automatic logic [7:0] limit_update(input logic [7:0] old,
                                                input logic [7:0] wr,
                                                input logic [7:0] code);
        logic [7:0] res;
        res = old;
        if (upper_hmv(wr[7:4]) >= code_hmv(code)) begin
            res[7:4] = wr[7:4];
        end
        if (lower_hmv(wr[3:0]) <= code_hmv(code)) begin
            res[3:0] = wr[3:0];
        end
        limit_update = res;
    endfunction

    function automatic logic code_in_range(input logic [7:0] code,
                                           input logic [7:0] lim);
        code_in_range = (code_hmv(code) >= lower_hmv(lim[3:0]))
                     && (code_hmv(code) <= upper_hmv(lim[7:4]));
    endfunction

    logic          agg_good;
    logic [CW-1:0] delay_target;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        // Two-stage synchronisers for pins
        state_next.good_meta = ch_good_i;
        state_next.good_sync = state_reg.good_meta;
        state_next.cfg_meta  = transient_config_pin_i;
        state_next.cfg_sync  = state_reg.cfg_meta;

        if (reg_wr_i) begin
            case (reg_addr_i)
                pg_regs_pkg::CH2_OUTPUT_CODE_ADDR: begin
                    if (code_in_range(reg_wdata_i, state_reg.ch2_limits)) begin
                        state_next.ch2_code = reg_wdata_i;
                    end
                end
                pg_regs_pkg::CH3_OUTPUT_CODE_ADDR: begin
                    if (code_in_range(reg_wdata_i, state_reg.ch3_limits)) begin
                        state_next.ch3_code = reg_wdata_i;
                    end
                end
                pg_regs_pkg::CH2_OUTPUT_LIMITS_ADDR: begin
                    state_next.ch2_limits = limit_update(state_reg.ch2_limits,
                        reg_wdata_i, state_reg.ch2_code);
                end
                pg_regs_pkg::CH3_OUTPUT_LIMITS_ADDR: begin
                    state_next.ch3_limits = limit_update(state_reg.ch3_limits,
                        reg_wdata_i, state_reg.ch3_code);
                end
                pg_regs_pkg::FAST_TRANSIENT_CONFIG_ADDR: begin
                    state_next.transient =
                        reg_wdata_i[pg_regs_pkg::TRANSIENT_MSB:0];
                end
                pg_regs_pkg::POWER_GOOD_CONFIG_ADDR: begin
                    state_next.delay_en =
                        reg_wdata_i[pg_regs_pkg::GOOD_DELAY_BIT];
                    state_next.exclude =
                        reg_wdata_i[pg_regs_pkg::GOOD_EXCLUDE_MSB:0];
                end
                default: begin
                end
            endcase
        end

        // Pin low forces every channel's transient code to disabled
        state_next.transient_eff = state_reg.cfg_sync
                                 ? state_reg.transient : 6'h00;

        // Good pin with optional assertion delay
        if (!agg_good) begin
            state_next.delay_cnt = '0;
            state_next.pin       = 1'b0;
        end else if (!state_reg.delay_en) begin
            state_next.pin = 1'b1;
        end else if (state_reg.delay_cnt >= delay_target) begin
            state_next.pin = 1'b1;
        end else begin
            state_next.delay_cnt = state_reg.delay_cnt + CW'(1);
        end

        // Registered read data, unmapped and reserved bits read zero
        case (reg_addr_i)
            pg_regs_pkg::CH2_OUTPUT_CODE_ADDR:
                state_next.rdata = state_reg.ch2_code;
            pg_regs_pkg::CH3_OUTPUT_CODE_ADDR:
                state_next.rdata = state_reg.ch3_code;
            pg_regs_pkg::CH2_OUTPUT_LIMITS_ADDR:
                state_next.rdata = state_reg.ch2_limits;
            pg_regs_pkg::CH3_OUTPUT_LIMITS_ADDR:
                state_next.rdata = state_reg.ch3_limits;
            pg_regs_pkg::FAST_TRANSIENT_CONFIG_ADDR:
                state_next.rdata = {2'h0, state_reg.transient};
            pg_regs_pkg::POWER_GOOD_CONFIG_ADDR:
                state_next.rdata = {3'h0, state_reg.delay_en, 1'b0,
                                    state_reg.exclude};
            pg_regs_pkg::POWER_GOOD_LIVE_STATUS_ADDR:
                state_next.rdata = {5'h00, state_reg.good_sync};
            default:
                state_next.rdata = 8'h00;
        endcase
    end

    // Excluded channels count as good
    assign agg_good = &(state_reg.good_sync | state_reg.exclude);
    assign delay_target = timer_scale_x8_i ? CW'(TSET_X8_CYCLES - 1)
                                           : CW'(TSET_X1_CYCLES - 1);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg               <= '0;
            state_reg.ch2_code      <= pg_regs_pkg::OUTPUT_CODE_RST;
            state_reg.ch3_code      <= pg_regs_pkg::OUTPUT_CODE_RST;
            state_reg.ch2_limits    <= pg_regs_pkg::OUTPUT_LIMITS_RST;
            state_reg.ch3_limits    <= pg_regs_pkg::OUTPUT_LIMITS_RST;
            state_reg.transient     <= pg_regs_pkg::TRANSIENT_RST;
            state_reg.delay_en      <=
                pg_regs_pkg::GOOD_CONFIG_RST[pg_regs_pkg::GOOD_DELAY_BIT];
            state_reg.exclude       <=
                pg_regs_pkg::GOOD_CONFIG_RST[pg_regs_pkg::GOOD_EXCLUDE_MSB:0];
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata_o                 = state_reg.rdata;
    assign ch2_output_code_o           = state_reg.ch2_code;
    assign ch3_output_code_o           = state_reg.ch3_code;
    assign ch1_transient_sensitivity_o = state_reg.transient_eff[1:0];
    assign ch2_transient_sensitivity_o = state_reg.transient_eff[3:2];
    assign ch3_transient_sensitivity_o = state_reg.transient_eff[5:4];
    assign aggregate_good_pin_o        = state_reg.pin;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    ch2_upper_reject_a: assert property (
        reg_wr_i && reg_addr_i == pg_regs_pkg::CH2_OUTPUT_LIMITS_ADDR
        && upper_hmv(reg_wdata_i[7:4]) < code_hmv(state_reg.ch2_code)
        |=> state_reg.ch2_limits[7:4] == $past(state_reg.ch2_limits[7:4]))
        else $error("ch2 upper limit write not discarded");

    ch2_lower_reject_a: assert property (
        reg_wr_i && reg_addr_i == pg_regs_pkg::CH2_OUTPUT_LIMITS_ADDR
        && lower_hmv(reg_wdata_i[3:0]) > code_hmv(state_reg.ch2_code)
        |=> state_reg.ch2_limits[3:0] == $past(state_reg.ch2_limits[3:0]))
        else $error("ch2 lower limit write not discarded");

    ch3_upper_reject_a: assert property (
        reg_wr_i && reg_addr_i == pg_regs_pkg::CH3_OUTPUT_LIMITS_ADDR
        && upper_hmv(reg_wdata_i[7:4]) < code_hmv(state_reg.ch3_code)
        |=> state_reg.ch3_limits[7:4] == $past(state_reg.ch3_limits[7:4]))
        else $error("ch3 upper limit write not discarded");

    ch3_lower_reject_a: assert property (
        reg_wr_i && reg_addr_i == pg_regs_pkg::CH3_OUTPUT_LIMITS_ADDR
        && lower_hmv(reg_wdata_i[3:0]) > code_hmv(state_reg.ch3_code)
        |=> state_reg.ch3_limits[3:0] == $past(state_reg.ch3_limits[3:0]))
        else $error("ch3 lower limit write not discarded");

    transient_off_a: assert property (
        !state_reg.cfg_sync |=> ch1_transient_sensitivity_o == 2'h0
        && ch2_transient_sensitivity_o == 2'h0
        && ch3_transient_sensitivity_o == 2'h0)
        else $error("transient codes not forced off");

    transient_store_a: assert property (
        (reg_wr_i
         && reg_addr_i == pg_regs_pkg::FAST_TRANSIENT_CONFIG_ADDR)
        ##1 state_reg.cfg_sync
        |=> {ch3_transient_sensitivity_o, ch2_transient_sensitivity_o,
             ch1_transient_sensitivity_o} == $past(reg_wdata_i[5:0], 2))
        else $error("transient code not applied");

    pin_drop_a: assert property (
        !agg_good |=> !aggregate_good_pin_o)
        else $error("good pin high while aggregate bad");

    pin_nodelay_a: assert property (
        agg_good && !state_reg.delay_en |=> aggregate_good_pin_o)
        else $error("good pin not immediate without delay");

    pin_delay_a: assert property (
        $rose(aggregate_good_pin_o) && $past(state_reg.delay_en)
        |-> $past(state_reg.delay_cnt) == $past(delay_target))
        else $error("good pin rose before delay expired");

    live_status_a: assert property (
        reg_addr_i == pg_regs_pkg::POWER_GOOD_LIVE_STATUS_ADDR
        |=> reg_rdata_o == {5'h00, $past(state_reg.good_sync)})
        else $error("live status read mismatch");

    code_reject_a: assert property (
        reg_wr_i && reg_addr_i == pg_regs_pkg::CH2_OUTPUT_CODE_ADDR
        && !code_in_range(reg_wdata_i, state_reg.ch2_limits)
        |=> $stable(ch2_output_code_o))
        else $error("out of range ch2 code accepted");

    reserved_zero_a: assert property (
        reg_addr_i == pg_regs_pkg::POWER_GOOD_CONFIG_ADDR
        |=> reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[3] == 1'b0)
        else $error("reserved bits read nonzero");

    pin_delayed_c: cover property (
        state_reg.delay_en && agg_good ##1 $rose(aggregate_good_pin_o));
    limit_reject_c: cover property (
        reg_wr_i && reg_addr_i == pg_regs_pkg::CH2_OUTPUT_LIMITS_ADDR
        && upper_hmv(reg_wdata_i[7:4]) < code_hmv(state_reg.ch2_code));
    all_excluded_c: cover property (
        state_reg.exclude == 3'h7 && aggregate_good_pin_o);
endmodule

// File: bench/reg_host_model.sv
// Register-port host model issuing writes and reads
`timescale 1ns/1ps
module reg_host_model (
    input  wire logic       core_clk_i,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_wr_o,
    input  wire logic [7:0] reg_rdata_i
);
    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
    end
    // One-cycle strobe; write data is scrambled once released
    task automatic write_reg(input logic [7:0] addr,
                             input logic [7:0] data);
        @(posedge core_clk_i);
        reg_addr_o  <= addr;
        reg_wdata_o <= data;
        reg_wr_o    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_o    <= 1'b0;
        reg_wdata_o <= ~data;
    endtask
    // Read data lags the address by one edge
    task automatic read_reg(input logic [7:0] addr,
                            output logic [7:0] data);
        @(posedge core_clk_i);
        reg_addr_o <= addr;
        @(posedge core_clk_i);
        #1;
        data = reg_rdata_i;
    endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the limit and power-good register slice
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module tb;
    localparam int X1 = 5;
    localparam int X8 = 9;
    localparam logic [7:0] LIM_TBL [6][3] = '{
        '{8'hff, 8'h11, 8'h01}, '{8'hf0, 8'h20, 8'hf1},
        '{8'hf1, 8'h20, 8'h80}, '{8'h09, 8'h01, 8'h08},
        '{8'h08, 8'h01, 8'h09}, '{8'h80, 8'hff, 8'h73}};
    logic       core_clk_i;
    logic       rst_i;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic [7:0] reg_rdata;
    logic [2:0] ch_good;
    logic       cfg_pin;
    logic       scale_x8;
    logic [7:0] code2;
    logic [7:0] code3;
    logic [1:0] sens1;
    logic [1:0] sens2;
    logic [1:0] sens3;
    logic       good_pin;
    int         num_errors;
    int         n_tests;
    dvs_limit_powergood_regs #(.TSET_X1_CYCLES(X1), .TSET_X8_CYCLES(X8))
    u_dvs_limit_powergood_regs (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rdata_o(reg_rdata),
        .ch_good_i(ch_good), .transient_config_pin_i(cfg_pin),
        .timer_scale_x8_i(scale_x8), .ch2_output_code_o(code2),
        .ch3_output_code_o(code3), .ch1_transient_sensitivity_o(sens1),
        .ch2_transient_sensitivity_o(sens2),
        .ch3_transient_sensitivity_o(sens3),
        .aggregate_good_pin_o(good_pin));
    reg_host_model u_reg_host_model (
        .core_clk_i(core_clk_i), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rdata_i(reg_rdata));
    // ------------------------------------------------------------------
    // Helpers; voltages in half-millivolts with a 600 mV trim reference
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_reg_host_model.write_reg(a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_reg_host_model.read_reg(a, d);
        `CHK(d, e)
    endtask
    task automatic settle;
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask
    function automatic logic [7:0] exp_lim(logic [7:0] w, logic [7:0] c);
        int v;
        v = 816 + 3 * c;
        exp_lim = 8'h00;
        if (1584 - 24 * w[7:4] >= v) exp_lim[7:4] = w[7:4];
        if (819 + 24 * w[3:0] <= v) exp_lim[3:0] = w[3:0];
    endfunction
    function automatic logic code_ok(logic [7:0] l, logic [7:0] c);
        code_ok = (816 + 3 * c >= 819 + 24 * l[3:0]) &&
                  (816 + 3 * c <= 1584 - 24 * l[7:4]);
    endfunction
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic reset_case;
        rd_chk(8'hdd, 8'h00);
        rd_chk(8'hde, 8'h00);
        rd_chk(8'hdf, 8'h3f);
        rd_chk(8'he0, 8'h10);
        rd_chk(8'he1, 8'h00);
        `CHK({sens3, sens2, sens1}, 6'h3f)
        wr(8'hdf, 8'hff);
        rd_chk(8'hdf, 8'h3f);
        wr(8'he0, 8'hff);
        rd_chk(8'he0, 8'h17);
        wr(8'he1, 8'hff);
        rd_chk(8'he1, 8'h00);
        wr(8'h55, 8'hff);
        rd_chk(8'h55, 8'h00);
        wr(8'hd9, 8'h00);
        rd_chk(8'hd9, 8'h80);
    endtask
    task automatic lim_case(input logic ch3, input logic [7:0] c,
                            input logic [7:0] l, input logic [7:0] p);
        logic [7:0] ca;
        logic [7:0] la;
        logic [7:0] le;
        logic [7:0] ce;
        ca = ch3 ? 8'hda : 8'hd9;
        la = ch3 ? 8'hde : 8'hdd;
        le = exp_lim(l, c);
        ce = code_ok(le, p) ? p : c;
        wr(la, 8'h00);
        wr(ca, c);
        wr(la, l);
        rd_chk(la, le);
        wr(ca, p);
        rd_chk(ca, ce);
        `CHK(ch3 ? code3 : code2, ce)
    endtask
    task automatic transient_case;
        logic [5:0] v;
        for (int i = 0; i < 4; i++) begin
            v = {2'(i), 2'(i + 1), 2'(i + 2)};
            wr(8'hdf, {2'h0, v});
            rd_chk(8'hdf, {2'h0, v});
            `CHK({sens3, sens2, sens1}, v)
            cfg_pin <= 1'b0;
            settle;
            `CHK({sens3, sens2, sens1}, 6'h00)
            cfg_pin <= 1'b1;
            settle;
            `CHK({sens3, sens2, sens1}, v)
        end
    endtask
    task automatic good_case;
        for (int m = 0; m < 8; m++) begin
            wr(8'he0, 8'(m));
            for (int g = 0; g < 8; g++) begin
                ch_good <= 3'(g);
                settle;
                `CHK(good_pin, &(3'(g) | 3'(m)))
                rd_chk(8'he1, 8'(g));
            end
        end
    endtask
    task automatic delay_case(input logic x8, input int tset);
        int n;
        wr(8'he0, 8'h10);
        ch_good <= 3'b000;
        scale_x8 <= x8;
        settle;
        `CHK(good_pin, 1'b0)
        ch_good <= 3'b111;
        repeat (tset) @(posedge core_clk_i);
        #1;
        `CHK(good_pin, 1'b0)
        n = 0;
        while (good_pin !== 1'b1 && n < 8) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        `CHK(good_pin, 1'b1)
        `CHK(n, 2)
        ch_good <= 3'b011;
        settle;
        `CHK(good_pin, 1'b0)
    endtask
    task automatic final_report;
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        num_errors++;
        final_report;
    end
    initial begin
        rst_i = 1'b1;
        ch_good = 3'b000;
        cfg_pin = 1'b1;
        scale_x8 = 1'b0;
        num_errors = 0;
        n_tests = 0;
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        reset_case;
        for (int ch = 0; ch < 2; ch++) begin
            for (int i = 0; i < 6; i++) begin
                lim_case(ch[0], LIM_TBL[i][0], LIM_TBL[i][1], LIM_TBL[i][2]);
            end
        end
        transient_case;
        good_case;
        delay_case(1'b0, X1);
        delay_case(1'b1, X8);
        final_report;
    end
endmodule
